/* common/hdsp_pkg.sv */
// Constants, register map and field layout of the compensation path
package hdsp_pkg;
	// =====================================================
	// Clock and update rates
	localparam int CLK_HZ = 125_000_000;
	localparam int SLOW_UPDATE_HZ = 16_000;
	localparam int FAST_UPDATE_HZ = 64_000;
	localparam int SLOW_DIV = CLK_HZ / SLOW_UPDATE_HZ;
	localparam int FAST_DIV = CLK_HZ / FAST_UPDATE_HZ;
	// =====================================================
	// Data formats
	localparam int DW = 12;
	localparam int AW = 7;
	localparam int RW = 16;
	localparam int POINTS = 33;
	localparam int SEG_BITS = 5;
	localparam int FRAC_BITS = 7;
	localparam logic [11:0] FULL_CODE = 12'hfff;
	localparam logic signed [8:0] REF_TEMP = 9'sd25;
	localparam int GAIN_SHIFT = 11;
	localparam int SENS_SHIFT = 20;
	localparam int TC1_SHIFT = 4;
	localparam int OFS_SHIFT = 24;
	localparam logic signed [11:0] OFS_SCALE = 12'sd906;
	localparam int CLAMP_STEP_SHIFT = 5;
	// =====================================================
	// Register offsets
	localparam logic [6:0] ADDR_CTRL = 7'h00;
	localparam logic [6:0] ADDR_OFS_TC = 7'h01;
	localparam logic [6:0] ADDR_TC1_COLD = 7'h02;
	localparam logic [6:0] ADDR_TC1_HOT = 7'h03;
	localparam logic [6:0] ADDR_TC2_COLD = 7'h04;
	localparam logic [6:0] ADDR_TC2_HOT = 7'h05;
	localparam logic [6:0] ADDR_CENTER = 7'h06;
	localparam logic [6:0] ADDR_COARSE = 7'h07;
	localparam logic [6:0] ADDR_GAIN = 7'h08;
	localparam logic [6:0] ADDR_TRIM = 7'h09;
	localparam logic [6:0] ADDR_CLAMP_HI = 7'h0a;
	localparam logic [6:0] ADDR_CLAMP_LO = 7'h0b;
	localparam logic [6:0] ADDR_STATUS = 7'h0c;
	localparam logic [6:0] ADDR_TEMP = 7'h0d;
	localparam logic [6:0] ADDR_CURVE = 7'h40;
	// =====================================================
	// Control fields
	localparam int CTRL_BW_LSB = 0;
	localparam int CTRL_TBL_VALID = 2;
	localparam int CTRL_IN_INV = 3;
	localparam int CTRL_OUT_INV = 4;
	localparam int CTRL_SENT_SEL = 5;
	// =====================================================
	// Reset values
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [9:0] COARSE_RST = 10'h100;
	localparam logic [11:0] GAIN_RST = 12'h800;
	localparam logic [7:0] CLAMP_HI_RST = 8'h80;
	localparam logic [7:0] CLAMP_LO_RST = 8'h00;
	localparam logic [1:0] BW_SLOW = 2'h0;
endpackage : hdsp_pkg

/* logic/hdsp_path.sv */
// Temperature compensation, gain, linearization and clamp path
`timescale 1ns/10ps
// Notes on behaviour
// - Bandwidth code sets sample update rate.
// - Other bandwidths keep full output resolution.
// - Offset drift term linear in temperature.
// - Cold set below 25, hot above.
// - Zero coefficients disable; first then second.
// - Compensation formula with center offset term.
// - Temperature delta is ambient minus 25.
// - Gain follows bandwidth and compensation.
// - Output is gain times value plus trim.
// - Trim is signed, up to half scale.
// - 33-point curve over 32 equal segments.
// - Curve points rewritable during operation.
// - Points 0..4096; 128 steps give unity.
// - Output invert flips final polarity.
// - Input invert flips value entering curve.
// - Clamp limits default to full and zero.
// - Protocol select routes to PWM or SENT.
// - Clamp steps are 1/128 of scale.
module hdsp_path #(
	parameter int UPD_DIV_SLOW = hdsp_pkg::SLOW_DIV,
	parameter int UPD_DIV_FAST = hdsp_pkg::FAST_DIV
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [hdsp_pkg::AW-1:0] addr_i,
	input wire logic [hdsp_pkg::RW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [hdsp_pkg::RW-1:0] rdata_o,
	input wire logic [hdsp_pkg::DW-1:0] sample_i,
	input wire logic sample_valid_i,
	input wire logic signed [8:0] ambient_temp_i,
	output logic [hdsp_pkg::DW-1:0] pwm_value_o,
	output logic pwm_valid_o,
	output logic [hdsp_pkg::DW-1:0] sent_value_o,
	output logic sent_valid_o
);
	import hdsp_pkg::*;

	// =====================================================
	// Parameter checks
	if (UPD_DIV_SLOW < 2 || UPD_DIV_FAST < 2 || UPD_DIV_SLOW > 65535 || UPD_DIV_FAST > 65535)
	begin : g_bad_div
		$error("update dividers must lie in 2..65535");
	end

	// Saturate a wide signed value into the unsigned output code range
	function automatic logic [11:0] sat_code(input logic signed [47:0] v);
		if (v < 48'sd0) begin
			sat_code = 12'h000;
		end else if (v > 48'sd4095) begin
			sat_code = FULL_CODE;
		end else begin
			sat_code = v[11:0];
		end
	endfunction : sat_code

	// =====================================================
	// Configuration registers
	logic [5:0] ctrl_r;
	logic signed [7:0] ofs_tc_r;
	logic signed [9:0] tc1_cold_r, tc1_hot_r;
	logic signed [7:0] tc2_cold_r, tc2_hot_r;
	logic signed [11:0] center_r;
	logic [9:0] coarse_r;
	logic [11:0] gain_r;
	logic signed [11:0] trim_r;
	logic [7:0] clamp_hi_r, clamp_lo_r;
	logic [12:0] curve_r [0:POINTS-1];
	logic [11:0] status_r;
	logic [RW-1:0] rdata_r;
	logic [5:0] curve_idx;

	assign curve_idx = 6'(addr_i - ADDR_CURVE);

	// Software writes; the path keeps running while points change
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_r <= CTRL_RST;
			ofs_tc_r <= '0;
			tc1_cold_r <= '0;
			tc1_hot_r <= '0;
			tc2_cold_r <= '0;
			tc2_hot_r <= '0;
			center_r <= '0;
			coarse_r <= COARSE_RST;
			gain_r <= GAIN_RST;
			trim_r <= '0;
			clamp_hi_r <= CLAMP_HI_RST;
			clamp_lo_r <= CLAMP_LO_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				ADDR_CTRL: ctrl_r <= wdata_i[5:0];
				ADDR_OFS_TC: ofs_tc_r <= wdata_i[7:0];
				ADDR_TC1_COLD: tc1_cold_r <= wdata_i[9:0];
				ADDR_TC1_HOT: tc1_hot_r <= wdata_i[9:0];
				ADDR_TC2_COLD: tc2_cold_r <= wdata_i[7:0];
				ADDR_TC2_HOT: tc2_hot_r <= wdata_i[7:0];
				ADDR_CENTER: center_r <= wdata_i[11:0];
				ADDR_COARSE: coarse_r <= wdata_i[9:0];
				ADDR_GAIN: gain_r <= wdata_i[11:0];
				ADDR_TRIM: trim_r <= wdata_i[11:0];
				ADDR_CLAMP_HI: clamp_hi_r <= wdata_i[7:0];
				ADDR_CLAMP_LO: clamp_lo_r <= wdata_i[7:0];
				default: ;
			endcase
		end
	end

	// Curve table: no reset, reloaded by software before it is marked valid
	always_ff @(posedge clk_i) begin
		if (wr_i && addr_i >= ADDR_CURVE && curve_idx < 6'(POINTS)) begin
			// Compare the whole word so that large codes saturate instead of wrapping
			if (wdata_i > 16'h1000) begin
				curve_r[curve_idx[5:0]] <= 13'h1000;
			end else begin
				curve_r[curve_idx[5:0]] <= wdata_i[12:0];
			end
		end
	end

	// Read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_r <= '0;
		end else if (rd_i) begin
			unique case (addr_i)
				ADDR_CTRL: rdata_r <= RW'(ctrl_r);
				ADDR_OFS_TC: rdata_r <= RW'(ofs_tc_r);
				ADDR_TC1_COLD: rdata_r <= RW'(tc1_cold_r);
				ADDR_TC1_HOT: rdata_r <= RW'(tc1_hot_r);
				ADDR_TC2_COLD: rdata_r <= RW'(tc2_cold_r);
				ADDR_TC2_HOT: rdata_r <= RW'(tc2_hot_r);
				ADDR_CENTER: rdata_r <= RW'(center_r);
				ADDR_COARSE: rdata_r <= RW'(coarse_r);
				ADDR_GAIN: rdata_r <= RW'(gain_r);
				ADDR_TRIM: rdata_r <= RW'(trim_r);
				ADDR_CLAMP_HI: rdata_r <= RW'(clamp_hi_r);
				ADDR_CLAMP_LO: rdata_r <= RW'(clamp_lo_r);
				ADDR_STATUS: rdata_r <= RW'(status_r);
				ADDR_TEMP: rdata_r <= RW'(ambient_temp_i);
				default: begin
					if (addr_i >= ADDR_CURVE && curve_idx < 6'(POINTS)) begin
						rdata_r <= RW'(curve_r[curve_idx[5:0]]);
					end else begin
						rdata_r <= '0;
					end
				end
			endcase
		end
	end
	assign rdata_o = rdata_r;

	// =====================================================
	// Update tick; a bandwidth change keeps the count, which ticks at once if already past the new divider
	logic [15:0] tick_cnt_r;
	logic [15:0] tick_div;
	logic tick;
	logic slow_bw;

	assign slow_bw = ctrl_r[CTRL_BW_LSB +: 2] == BW_SLOW;
	assign tick_div = slow_bw ? 16'(UPD_DIV_SLOW) : 16'(UPD_DIV_FAST);
	assign tick = tick_cnt_r >= tick_div - 16'h0001;

	always_ff @(posedge clk_i) begin
		if (reset_i || tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// Latest converter sample; only the one present at a tick is used
	logic [11:0] sample_r;
	logic have_r;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sample_r <= '0;
			have_r <= 1'b0;
		end else if (sample_valid_i) begin
			sample_r <= sample_i;
			have_r <= 1'b1;
		end
	end

	// =====================================================
	// Stage 1: import sample and temperature delta
	logic [11:0] s1_y_r;
	logic signed [8:0] s1_dt_r;
	logic s1_v_r;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s1_y_r <= '0;
			s1_dt_r <= '0;
			s1_v_r <= 1'b0;
		end else begin
			s1_v_r <= tick && have_r;
			if (tick) begin
				s1_y_r <= sample_r;
				s1_dt_r <= ambient_temp_i - REF_TEMP;
			end
		end
	end

	// =====================================================
	// Stage 2: temperature compensation
	logic signed [9:0] tc1_sel;
	logic signed [7:0] tc2_sel;
	logic signed [47:0] sens_factor, sens_corr, ofs_corr, comp_sum;
	logic [11:0] s2_y_r;
	logic s2_v_r;

	// Cold set below reference, hot set otherwise; at the reference delta is zero
	assign tc1_sel = s1_dt_r < 0 ? tc1_cold_r : tc1_hot_r;
	assign tc2_sel = s1_dt_r < 0 ? tc2_cold_r : tc2_hot_r;
	// A zero coefficient contributes nothing, so that order is off
	assign sens_factor = ((48'(tc1_sel) * 48'(s1_dt_r)) <<< TC1_SHIFT)
		+ 48'(tc2_sel) * 48'(s1_dt_r) * 48'(s1_dt_r);
	assign sens_corr = (sens_factor * (48'(signed'({1'b0, s1_y_r})) - 48'(center_r)))
		>>> SENS_SHIFT;
	assign ofs_corr = (48'(ofs_tc_r) * 48'(signed'({1'b0, coarse_r})) * 48'(s1_dt_r)
		* 48'(OFS_SCALE)) >>> OFS_SHIFT;
	assign comp_sum = 48'(signed'({1'b0, s1_y_r})) + sens_corr + ofs_corr;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s2_y_r <= '0;
			s2_v_r <= 1'b0;
		end else begin
			s2_v_r <= s1_v_r;
			if (s1_v_r) begin
				s2_y_r <= sat_code(comp_sum);
			end
		end
	end

	// =====================================================
	// Stage 3: gain and quiescent trim, after compensation
	logic signed [47:0] gain_sum;
	logic [11:0] s3_y_r;
	logic s3_v_r;

	assign gain_sum = ((48'(gain_r) * 48'(s2_y_r)) >>> GAIN_SHIFT) + 48'(trim_r);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s3_y_r <= '0;
			s3_v_r <= 1'b0;
		end else begin
			s3_v_r <= s2_v_r;
			if (s2_v_r) begin
				s3_y_r <= sat_code(gain_sum);
			end
		end
	end

	// =====================================================
	// Stage 4: linearization and polarity
	logic [11:0] lin_in;
	logic [4:0] seg;
	logic [6:0] frac;
	logic [12:0] p_lo, p_hi;
	logic signed [47:0] lin_val;
	logic [11:0] lin_out;
	logic [11:0] s4_y_r;
	logic s4_v_r;

	assign lin_in = ctrl_r[CTRL_IN_INV] ? FULL_CODE - s3_y_r : s3_y_r;
	assign seg = lin_in[FRAC_BITS +: SEG_BITS];
	assign frac = lin_in[FRAC_BITS-1:0];
	assign p_lo = curve_r[seg];
	assign p_hi = curve_r[6'(seg) + 6'h01];
	// Straight-line interpolation: 128-code point steps reproduce the input
	// Signed step so falling segments shift arithmetically instead of wrapping
	assign lin_val = $signed(48'(p_lo))
		+ (($signed(48'(p_hi)) - $signed(48'(p_lo))) * $signed(48'(frac)) >>> FRAC_BITS);
	assign lin_out = ctrl_r[CTRL_TBL_VALID] ? sat_code(lin_val) : s3_y_r;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s4_y_r <= '0;
			s4_v_r <= 1'b0;
		end else begin
			s4_v_r <= s3_v_r;
			if (s3_v_r) begin
				s4_y_r <= ctrl_r[CTRL_OUT_INV] ? FULL_CODE - lin_out : lin_out;
			end
		end
	end

	// =====================================================
	// Stage 5: clamp, resolution and protocol routing
	logic [12:0] hi_lim, lo_lim;
	logic [11:0] clamped, res_val;
	logic [11:0] out_r;
	logic out_v_r;

	// Each clamp code step is 32 output codes; full step count means full scale
	assign hi_lim = 13'(clamp_hi_r) << CLAMP_STEP_SHIFT;
	assign lo_lim = 13'(clamp_lo_r) << CLAMP_STEP_SHIFT;
	always_comb begin
		if (13'(s4_y_r) > hi_lim) begin
			clamped = hi_lim > 13'(FULL_CODE) ? FULL_CODE : hi_lim[11:0];
		end else if (13'(s4_y_r) < lo_lim) begin
			clamped = lo_lim > 13'(FULL_CODE) ? FULL_CODE : lo_lim[11:0];
		end else begin
			clamped = s4_y_r;
		end
	end
	// Slow bandwidth drops the lowest bit; the rest keep all twelve
	assign res_val = slow_bw ? {clamped[11:1], 1'b0} : clamped;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			out_r <= '0;
			out_v_r <= 1'b0;
			status_r <= '0;
		end else begin
			out_v_r <= s4_v_r;
			if (s4_v_r) begin
				out_r <= res_val;
				status_r <= res_val;
			end
		end
	end

	// Only the selected encoder sees a valid strobe
	assign pwm_value_o = out_r;
	assign sent_value_o = out_r;
	assign pwm_valid_o = out_v_r && !ctrl_r[CTRL_SENT_SEL];
	assign sent_valid_o = out_v_r && ctrl_r[CTRL_SENT_SEL];
endmodule : hdsp_path

/* testbench/hdsp_path_sva.sv */
// Concurrent checks on the compensation path ports
`timescale 1ns/10ps
module hdsp_path_chk #(
	parameter int UPD_DIV_SLOW = 8,
	parameter int UPD_DIV_FAST = 4
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [hdsp_pkg::AW-1:0] addr_i,
	input wire logic [hdsp_pkg::RW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [hdsp_pkg::RW-1:0] rdata_o,
	input wire logic [hdsp_pkg::DW-1:0] sample_i,
	input wire logic sample_valid_i,
	input wire logic signed [8:0] ambient_temp_i,
	input wire logic [hdsp_pkg::DW-1:0] pwm_value_o,
	input wire logic pwm_valid_o,
	input wire logic [hdsp_pkg::DW-1:0] sent_value_o,
	input wire logic sent_valid_o
);
	import hdsp_pkg::*;
	logic [5:0] ctrl_r;
	logic [7:0] hi_r;
	logic [7:0] lo_r;
	logic [3:0] quiet_r;
	logic [12:0] hi_lim;
	logic [12:0] lo_lim;
	logic out_v;
	// =====================================================
	// Shadow settings
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_r <= CTRL_RST;
			hi_r <= CLAMP_HI_RST;
			lo_r <= CLAMP_LO_RST;
		end else if (wr_i) begin
			if (addr_i == ADDR_CTRL) ctrl_r <= wdata_i[5:0];
			if (addr_i == ADDR_CLAMP_HI) hi_r <= wdata_i[7:0];
			if (addr_i == ADDR_CLAMP_LO) lo_r <= wdata_i[7:0];
		end
	end
	// Results in flight may use old settings, so wait until writes settle
	always_ff @(posedge clk_i) begin
		if (reset_i || wr_i) quiet_r <= 4'h0;
		else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
	end
	assign hi_lim = hi_r[7] ? 13'h0fff : {hi_r, 5'h00};
	assign lo_lim = {lo_r, 5'h00};
	assign out_v = pwm_valid_o | sent_valid_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// =====================================================
	// Assertions
	chk_valid_gap: assert property (out_v |=> !out_v [*3])
		else $error("result strobes too close");
	chk_value_hold: assert property ($changed(pwm_value_o) |-> out_v)
		else $error("value moved without strobe");
	chk_same_value: assert property (pwm_value_o == sent_value_o)
		else $error("encoder values differ");
	chk_route_sel: assert property (out_v && quiet_r == 4'hf |-> sent_valid_o == ctrl_r[5])
		else $error("strobe on wrong encoder");
	chk_clamp_high: assert property (out_v && quiet_r == 4'hf |-> pwm_value_o <= hi_lim)
		else $error("value above high limit");
	chk_clamp_low: assert property (out_v && quiet_r == 4'hf && lo_r <= hi_r
		|-> pwm_value_o >= lo_lim)
		else $error("value below low limit");
	chk_slow_lsb: assert property (out_v && quiet_r == 4'hf && ctrl_r[1:0] == BW_SLOW
		|-> !pwm_value_o[0])
		else $error("slow rate kept low bit");
	chk_read_clamp: assert property (rd_i && addr_i == ADDR_CLAMP_HI
		|=> rdata_o == {8'h00, hi_r})
		else $error("clamp readback wrong");
	cover property (sent_valid_o);
	cover property (out_v && ctrl_r[4]);
	cover property (rd_i ##1 rdata_o != 16'h0000);
endmodule : hdsp_path_chk
bind hdsp_path hdsp_path_chk #(.UPD_DIV_SLOW(UPD_DIV_SLOW), .UPD_DIV_FAST(UPD_DIV_FAST)) u_chk (.*);

/* testbench/hdsp_fe_model.sv */
// Front-end converter model producing periodic samples
`timescale 1ns/10ps
module hdsp_fe_model (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [hdsp_pkg::DW-1:0] code_i,
	output logic [hdsp_pkg::DW-1:0] sample_o,
	output logic valid_o
);
	import hdsp_pkg::*;
	logic [1:0] cnt_r;
	// One conversion every third clock; the bus shows junk in between
	always_ff @(posedge clk_i) begin
		if (reset_i || cnt_r == 2'h2) cnt_r <= 2'h0;
		else cnt_r <= cnt_r + 2'h1;
		valid_o <= !reset_i && cnt_r == 2'h2;
		sample_o <= (!reset_i && cnt_r == 2'h2) ? code_i : ~code_i;
	end
endmodule : hdsp_fe_model

/* testbench/hdsp_path_tb.sv */
// Self-checking bench for the compensation path
`timescale 1ns/10ps
module hdsp_path_tb;
	import hdsp_pkg::*;
	logic clk_i, reset_i, wr_i, rd_i, last_sent;
	logic [6:0] addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [11:0] sample_i, code, pwm_value_o, sent_value_o;
	logic sample_valid_i, pwm_valid_o, sent_valid_o;
	logic signed [8:0] temp;
	int n_errors = 0;
	int check_count = 0;
	hdsp_path #(.UPD_DIV_SLOW(8), .UPD_DIV_FAST(4)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sample_i(sample_i), .sample_valid_i(sample_valid_i), .ambient_temp_i(temp),
		.pwm_value_o(pwm_value_o), .pwm_valid_o(pwm_valid_o), .sent_value_o(sent_value_o),
		.sent_valid_o(sent_valid_o));
	hdsp_fe_model u_fe (.clk_i(clk_i), .reset_i(reset_i), .code_i(code),
		.sample_o(sample_i), .valid_o(sample_valid_i));
	// =====================================================
	// Clock, watchdog and closing
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		complete_run();
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	// =====================================================
	// Bus and compare tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, exp);
	endtask : rd
	// Third result after a change is sure to carry the new sample and setting
	task automatic out(input logic [11:0] c, input logic [11:0] exp);
		int seen;
		seen = 0;
		@(posedge clk_i);
		code <= c;
		for (int i = 0; i < 200 && seen < 3; i++) begin
			@(posedge clk_i);
			#1;
			if ((pwm_valid_o | sent_valid_o) === 1'b1) seen++;
		end
		last_sent = sent_valid_o;
		chk(16'(seen), 16'h0003);
		chk({4'h0, pwm_value_o}, {4'h0, exp});
	endtask : out
	// =====================================================
	// Tests
	initial begin
		reset_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 7'h00;
		wdata_i = 16'h0000;
		code = 12'h000;
		temp = 9'sd25;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(ADDR_GAIN, 16'h0800);
		rd(ADDR_CLAMP_HI, 16'h0080);
		rd(ADDR_CTRL, 16'h0000);
		rd(7'h20, 16'h0000);
		out(12'h555, 12'h554);
		wr(ADDR_CTRL, 16'h0001);
		out(12'h555, 12'h555);
		$display("test rate done");
		wr(ADDR_GAIN, 16'h0400);
		out(12'h800, 12'h400);
		wr(ADDR_TRIM, 16'h0100);
		out(12'h800, 12'h500);
		wr(ADDR_GAIN, 16'h0800);
		out(12'hfff, 12'hfff);
		wr(ADDR_TRIM, 16'hf800);
		out(12'h400, 12'h000);
		wr(ADDR_TRIM, 16'h0000);
		$display("test gain done");
		wr(ADDR_TC1_HOT, 16'h0100);
		temp <= 9'sd50;
		out(12'h800, 12'h8c8);
		temp <= 9'sd0;
		out(12'h800, 12'h800);
		wr(ADDR_TC1_COLD, 16'h0100);
		out(12'h800, 12'h738);
		temp <= 9'sd50;
		wr(ADDR_TC2_HOT, 16'h0010);
		out(12'h800, 12'h8db);
		wr(ADDR_TC1_HOT, 16'h0000);
		wr(ADDR_TC2_HOT, 16'h0000);
		wr(ADDR_OFS_TC, 16'h0040);
		out(12'h800, 12'h816);
		wr(ADDR_OFS_TC, 16'h0000);
		temp <= 9'sd25;
		$display("test temperature done");
		wr(ADDR_CTRL, 16'h0011);
		out(12'h800, 12'h7ff);
		wr(ADDR_CTRL, 16'h0001);
		wr(ADDR_CLAMP_HI, 16'h0040);
		out(12'hfff, 12'h800);
		wr(ADDR_CLAMP_LO, 16'h0010);
		out(12'h000, 12'h200);
		wr(ADDR_CLAMP_HI, 16'h0080);
		wr(ADDR_CLAMP_LO, 16'h0000);
		$display("test clamp done");
		for (int i = 0; i < 33; i++) wr(ADDR_CURVE + 7'(i), 16'(i * 64));
		wr(ADDR_CTRL, 16'h0005);
		out(12'h800, 12'h400);
		wr(ADDR_CTRL, 16'h000d);
		out(12'h800, 12'h3ff);
		wr(ADDR_CTRL, 16'h0009);
		out(12'h800, 12'h800);
		wr(ADDR_CTRL, 16'h0005);
		wr(ADDR_CURVE + 7'h10, 16'h0100);
		out(12'h800, 12'h100);
		out(12'h7ff, 12'h105);
		wr(ADDR_CURVE + 7'h20, 16'h1fff);
		rd(ADDR_CURVE + 7'h20, 16'h1000);
		wr(ADDR_CURVE + 7'h1f, 16'h2000);
		rd(ADDR_CURVE + 7'h1f, 16'h1000);
		$display("test curve done");
		wr(ADDR_CTRL, 16'h0021);
		out(12'h123, 12'h123);
		chk({15'h0, last_sent}, 16'h0001);
		chk({4'h0, sent_value_o}, 16'h0123);
		rd(ADDR_STATUS, 16'h0123);
		rd(ADDR_TEMP, 16'h0019);
		$display("test protocol done");
		complete_run();
	end
endmodule : hdsp_path_tb
